// >>> pkg/scu_pkg.sv
/*
 * Shared types and constants of the subroutine call unit: request,
 * descriptor, memory and answer carriers, error codes and limits.
 * Assumes one clock domain shared with the sequencer and data memory.
 */
package scu_pkg;

  // ****************************************************************
  // Limits and codes
  // ****************************************************************
  localparam logic [3:0] SCU_MAX_DEPTH = 4'h8;
  localparam logic [3:0] SCU_ISR_MAX_DEPTH = 4'h1;
  localparam logic [4:0] SCU_MAX_PARAMS = 5'h10;
  localparam logic [6:0] SCU_SBR_MAX_SMALL = 7'h3F;
  localparam logic [6:0] SCU_SBR_MAX_LARGE = 7'h7F;
  localparam logic SCU_LARGE_VARIANT = 1'h1;
  localparam logic [15:0] SCU_ERR_NONE = 16'h0000;
  localparam logic [15:0] SCU_ERR_NEST = 16'h0008;
  localparam logic [15:0] SCU_ERR_INDIRECT = 16'h0006;
  localparam logic [1:0] SCU_ACC_MIN = 2'h1;
  localparam logic [15:0] SCU_SM_MIN_OFFSET = 16'h001E;
  localparam logic [31:0] SCU_STACK_ENTRY = 32'h0000_0001;
  localparam logic [6:0] SCU_LOCAL_BASE = 7'h00;
  localparam logic [2:0] SCU_BIT_LAST = 3'h7;

  // ****************************************************************
  // Enumerations
  // ****************************************************************
  typedef enum logic [1:0] {
    SCU_OP_NONE = 2'b00,
    SCU_OP_CALL = 2'b01,
    SCU_OP_RET = 2'b10,
    SCU_OP_CONDITIONAL_RETURN = 2'b11
  } scu_op_e;

  typedef enum logic [1:0] {
    SCU_DIR_IN = 2'b00,
    SCU_DIR_INOUT = 2'b01,
    SCU_DIR_OUT = 2'b10
  } scu_dir_e;

  typedef enum logic [1:0] {
    SCU_SZ_BIT = 2'b00,
    SCU_SZ_BYTE = 2'b01,
    SCU_SZ_WORD = 2'b10,
    SCU_SZ_UNSIGNED_DOUBLE_WORD = 2'b11
  } scu_size_e;

  typedef enum logic [1:0] {
    SCU_MD_DIRECT = 2'b00,
    SCU_MD_INDIRECT = 2'b01,
    SCU_MD_CONST = 2'b10,
    SCU_MD_ADDR = 2'b11
  } scu_mode_e;

  typedef enum logic [1:0] {
    SCU_ACT_NEXT = 2'b00,
    SCU_ACT_ENTER = 2'b01,
    SCU_ACT_RESUME = 2'b10
  } scu_act_e;

  // ****************************************************************
  // Carriers
  // ****************************************************************
  typedef struct packed {
    scu_op_e op;
    logic [6:0] subroutine_number;
    logic [15:0] call_pc;
    logic [15:0] next_pc;
    logic [4:0] nparam;
    logic in_isr;
    logic [31:0] stack;
  } scu_req_s;

  typedef struct packed {
    scu_dir_e dir;
    scu_size_e size;
    scu_mode_e mode;
    logic special_memory;
    logic acc_ind;
    logic [1:0] acc_idx;
    logic [2:0] bit_pos;
    logic [15:0] addr;
    logic [31:0] value;
  } scu_desc_s;

  typedef struct packed {
    logic req;
    logic we;
    logic local_mem;
    logic [2:0] frame;
    logic [15:0] addr;
    scu_size_e size;
    logic [2:0] bit_pos;
    logic [31:0] wdata;
  } scu_mem_s;

  typedef struct packed {
    logic valid;
    scu_act_e act;
    logic [6:0] subroutine_number;
    logic [15:0] pc;
    logic [31:0] stack;
    logic enable_out_flag;
    logic [15:0] err;
  } scu_rsp_s;

endpackage

// >>> hdl/scu_alloc.sv
/*
 * Local memory placement walker: gives the byte offset and bit position
 * of the current parameter and steps past it when told to.
 * Assumes the caller clears it before the first parameter of a walk.
 */
`timescale 1ns/10ps
module scu_alloc (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic clr,
  input wire logic adv,
  input wire scu_pkg::scu_size_e size,
  output logic [6:0] byte_off,
  output logic [2:0] bit_off
);
  import scu_pkg::*;

  logic [6:0] ptr_q;
  logic [2:0] bit_q;
  logic in_bits_q;
  logic [6:0] base;

  // ****************************************************************
  // Placement
  // ****************************************************************
  // A run of bits is closed by the next wider parameter
  always_comb begin
    base = (in_bits_q && size != SCU_SZ_BIT) ? ptr_q + 7'h01 : ptr_q;
    byte_off = base;
    bit_off = (size == SCU_SZ_BIT && in_bits_q) ? bit_q : 3'h0;
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      ptr_q <= SCU_LOCAL_BASE;
      bit_q <= 3'h0;
      in_bits_q <= 1'h0;
    end else if (clr) begin
      ptr_q <= SCU_LOCAL_BASE;
      bit_q <= 3'h0;
      in_bits_q <= 1'h0;
    end else if (adv) begin
      unique case (size)
        SCU_SZ_BIT: begin
          if (in_bits_q && bit_q == SCU_BIT_LAST) begin
            ptr_q <= ptr_q + 7'h01;
            bit_q <= 3'h0;
            in_bits_q <= 1'h0;
          end else begin
            bit_q <= in_bits_q ? bit_q + 3'h1 : 3'h1;
            in_bits_q <= 1'h1;
          end
        end
        SCU_SZ_BYTE: begin
          ptr_q <= base + 7'h01;
          in_bits_q <= 1'h0;
        end
        SCU_SZ_WORD: begin
          ptr_q <= base + 7'h02;
          in_bits_q <= 1'h0;
        end
        SCU_SZ_UNSIGNED_DOUBLE_WORD: begin
          ptr_q <= base + 7'h04;
          in_bits_q <= 1'h0;
        end
      endcase
    end
  end

endmodule // scu_alloc

// >>> hdl/scu_call_unit.sv
/*
 * Subroutine call and return unit: nesting control, logic stack save,
 * parameter copy into and out of the callee's local frame.
 * Assumes the sequencer answers descriptors combinationally from
 * desc_pc/desc_idx and that data memory acks each request on clk.
 */
// Operation
// - Call enters chosen subroutine; its end resumes after the call
// - Conditional return leaves only when the preceding logic result is true
// - Failed call clears enable-out; 0008 for nesting, 0006 for indirect fault
// - Calls nest up to eight levels from the main program
// - Subroutine entered from interrupt level may not call further
// - Subroutine number is constant, 0..63 small variants, 0..127 largest
// - Call saves logic stack, sets top one, clears rest; return restores
// - Accumulators are shared, never saved nor restored
// - At most sixteen parameters per call, all directions counted
// - Input gives direct contents, pointed-to contents, or the literal value
// - In-out read at call, written back there; no literals allowed
// - Inputs copied to callee local memory before the body runs
// - Outputs copied from local memory to caller locations at completion
// - Parameters placed sequentially in call order from local bit 0
// - One to eight consecutive bits packed into one local byte
// - Byte, word and double word parameters sit on byte boundaries
// - Values pass bit for bit, no type conversion
// - Address literals arrive as unsigned 32-bit double words
// - Widths fixed: one, two or four bytes; real is four bytes
// - Accumulator pointers index one or above; special memory outputs offset 30+
// - Recursive calls are allowed within the depth limit
`timescale 1ns/10ps
module scu_call_unit (
  input wire logic clk,
  input wire logic sys_rst,
  input wire scu_pkg::scu_req_s req,
  input wire scu_pkg::scu_desc_s desc,
  input wire logic mem_ack,
  input wire logic [31:0] mem_rdata,
  output logic busy,
  output logic [15:0] desc_pc,
  output logic [4:0] desc_idx,
  output scu_pkg::scu_mem_s mem,
  output scu_pkg::scu_rsp_s rsp,
  output logic [3:0] depth
);
  import scu_pkg::*;

  typedef enum logic [3:0] {
    SCU_ST_IDLE = 4'b0000,
    SCU_ST_CHECK = 4'b0001,
    SCU_ST_FETCH = 4'b0010,
    SCU_ST_PTR = 4'b0011,
    SCU_ST_SRC = 4'b0100,
    SCU_ST_LWR = 4'b0101,
    SCU_ST_ENTER = 4'b0110,
    SCU_ST_RDESC = 4'b0111,
    SCU_ST_RLRD = 4'b1000,
    SCU_ST_RPTR = 4'b1001,
    SCU_ST_RWR = 4'b1010,
    SCU_ST_RESUME = 4'b1011,
    SCU_ST_FAIL = 4'b1100,
    SCU_ST_NEXT = 4'b1101
  } scu_state_e;

  typedef struct packed {
    logic [15:0] ret_pc;
    logic [15:0] call_pc;
    logic [4:0] nparam;
    logic isr;
    logic [31:0] stack;
  } scu_frame_s;

  // ****************************************************************
  // Helpers
  // ****************************************************************
  function automatic logic desc_bad(input scu_desc_s d);
    logic lit;
    lit = (d.mode == SCU_MD_CONST) || (d.mode == SCU_MD_ADDR);
    desc_bad = (d.mode == SCU_MD_INDIRECT && d.acc_ind && d.acc_idx < SCU_ACC_MIN)
      || (d.dir != SCU_DIR_IN && lit)
      || (d.dir != SCU_DIR_IN && d.special_memory && d.addr < SCU_SM_MIN_OFFSET);
  endfunction

  function automatic scu_size_e eff_size(input scu_desc_s d);
    eff_size = (d.mode == SCU_MD_ADDR) ? SCU_SZ_UNSIGNED_DOUBLE_WORD : d.size;
  endfunction

  scu_state_e st_q;
  logic busy_q;
  scu_req_s req_q;
  scu_frame_s frame_q [8];
  logic [3:0] depth_q;
  logic [3:0] isr_cnt_q;
  logic [4:0] idx_q;
  logic [15:0] desc_pc_q;
  logic [15:0] ptr_q;
  logic [31:0] data_q;
  logic [15:0] err_q;
  scu_mem_s mem_q;
  scu_mem_s mem_d;
  scu_rsp_s rsp_q;
  scu_frame_s top;
  logic last;
  logic mem_st;
  logic adv;
  logic alloc_clr;
  logic [6:0] loc_byte;
  logic [2:0] loc_bit;
  logic [6:0] sbr_max;
  logic nest_full;

  assign top = frame_q[depth_q[2:0] - 3'h1];
  assign last = (idx_q == req_q.nparam - 5'h01);
  assign sbr_max = SCU_LARGE_VARIANT ? SCU_SBR_MAX_LARGE : SCU_SBR_MAX_SMALL;
  assign nest_full = (depth_q >= SCU_MAX_DEPTH)
    || (req.in_isr && isr_cnt_q >= SCU_ISR_MAX_DEPTH);
  assign mem_st = st_q inside {SCU_ST_PTR, SCU_ST_SRC, SCU_ST_LWR, SCU_ST_RLRD,
    SCU_ST_RPTR, SCU_ST_RWR};
  assign alloc_clr = (st_q == SCU_ST_IDLE) || (st_q == SCU_ST_CHECK);
  assign adv = (st_q == SCU_ST_FETCH && desc.dir == SCU_DIR_OUT)
    || (st_q == SCU_ST_RDESC && desc.dir == SCU_DIR_IN)
    || ((st_q == SCU_ST_LWR || st_q == SCU_ST_RWR) && mem_ack);

  scu_alloc u_alloc (
    .clk(clk),
    .sys_rst(sys_rst),
    .clr(alloc_clr),
    .adv(adv),
    .size(eff_size(desc)),
    .byte_off(loc_byte),
    .bit_off(loc_bit)
  );

  // ****************************************************************
  // Sequencing
  // ****************************************************************
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      st_q <= SCU_ST_IDLE;
      err_q <= SCU_ERR_NONE;
      busy_q <= 1'h0;
    end else begin
      // Busy next cycle: still working, answer pending, or a request taken now
      busy_q <= (st_q != SCU_ST_IDLE) || (req.op != SCU_OP_NONE);
      unique case (st_q)
        SCU_ST_IDLE: begin
          if (req.op == SCU_OP_CALL) begin
            if (nest_full) begin
              st_q <= SCU_ST_FAIL;
              err_q <= SCU_ERR_NEST;
            end else if (req.subroutine_number > sbr_max || req.nparam > SCU_MAX_PARAMS) begin
              st_q <= SCU_ST_FAIL;
              err_q <= SCU_ERR_INDIRECT;
            end else begin
              st_q <= (req.nparam == 5'h00) ? SCU_ST_ENTER : SCU_ST_CHECK;
            end
          end else if (req.op == SCU_OP_RET || req.op == SCU_OP_CONDITIONAL_RETURN) begin
            if ((req.op == SCU_OP_CONDITIONAL_RETURN && !req.stack[0]) || depth_q == 4'h0) begin
              st_q <= SCU_ST_NEXT;
            end else begin
              st_q <= (top.nparam == 5'h00) ? SCU_ST_RESUME : SCU_ST_RDESC;
            end
          end
        end
        // All operands are vetted before any local byte is written
        SCU_ST_CHECK: begin
          if (desc_bad(desc)) begin
            st_q <= SCU_ST_FAIL;
            err_q <= SCU_ERR_INDIRECT;
          end else if (last) begin
            st_q <= SCU_ST_FETCH;
          end
        end
        SCU_ST_FETCH: begin
          if (desc.dir == SCU_DIR_OUT) begin
            st_q <= last ? SCU_ST_ENTER : SCU_ST_FETCH;
          end else if (desc.mode == SCU_MD_CONST || desc.mode == SCU_MD_ADDR) begin
            st_q <= SCU_ST_LWR;
          end else if (desc.mode == SCU_MD_INDIRECT && !desc.acc_ind) begin
            st_q <= SCU_ST_PTR;
          end else begin
            st_q <= SCU_ST_SRC;
          end
        end
        SCU_ST_PTR: st_q <= mem_ack ? SCU_ST_SRC : SCU_ST_PTR;
        SCU_ST_SRC: st_q <= mem_ack ? SCU_ST_LWR : SCU_ST_SRC;
        SCU_ST_LWR: begin
          if (mem_ack) begin
            st_q <= last ? SCU_ST_ENTER : SCU_ST_FETCH;
          end
        end
        SCU_ST_RDESC: begin
          if (desc.dir == SCU_DIR_IN) begin
            st_q <= last ? SCU_ST_RESUME : SCU_ST_RDESC;
          end else begin
            st_q <= SCU_ST_RLRD;
          end
        end
        SCU_ST_RLRD: begin
          if (mem_ack) begin
            st_q <= (desc.mode == SCU_MD_INDIRECT && !desc.acc_ind) ? SCU_ST_RPTR : SCU_ST_RWR;
          end
        end
        SCU_ST_RPTR: st_q <= mem_ack ? SCU_ST_RWR : SCU_ST_RPTR;
        SCU_ST_RWR: begin
          if (mem_ack) begin
            st_q <= last ? SCU_ST_RESUME : SCU_ST_RDESC;
          end
        end
        SCU_ST_ENTER: st_q <= SCU_ST_IDLE;
        SCU_ST_RESUME: st_q <= SCU_ST_IDLE;
        SCU_ST_FAIL: st_q <= SCU_ST_IDLE;
        SCU_ST_NEXT: st_q <= SCU_ST_IDLE;
        default: st_q <= SCU_ST_IDLE;
      endcase
    end
  end

  // ****************************************************************
  // Request latch and descriptor index
  // ****************************************************************
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      req_q <= '0;
      idx_q <= 5'h00;
      desc_pc_q <= 16'h0000;
    end else if (st_q == SCU_ST_IDLE) begin
      idx_q <= 5'h00;
      if (req.op == SCU_OP_CALL) begin
        req_q <= req;
        desc_pc_q <= req.call_pc;
      end else if (req.op != SCU_OP_NONE) begin
        req_q <= req;
        req_q.nparam <= top.nparam;
        desc_pc_q <= top.call_pc;
      end
    end else if ((st_q == SCU_ST_CHECK) && last) begin
      idx_q <= 5'h00;
    end else if (!last && ((st_q == SCU_ST_CHECK) || adv)) begin
      idx_q <= idx_q + 5'h01;
    end
  end

  // ****************************************************************
  // Data path
  // ****************************************************************
  // Accumulator pointers are taken as given, the unit keeps no copy
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      ptr_q <= 16'h0000;
      data_q <= 32'h0000_0000;
    end else begin
      if (st_q == SCU_ST_FETCH) begin
        data_q <= desc.value;
        ptr_q <= desc.acc_ind ? desc.value[15:0] : desc.addr;
      end else if (st_q == SCU_ST_RDESC) begin
        ptr_q <= desc.acc_ind ? desc.value[15:0] : desc.addr;
      end
      if (mem_ack && (st_q == SCU_ST_PTR || st_q == SCU_ST_RPTR)) begin
        ptr_q <= mem_rdata[15:0];
      end
      if (mem_ack && (st_q == SCU_ST_SRC || st_q == SCU_ST_RLRD)) begin
        data_q <= mem_rdata;
      end
    end
  end

  always_comb begin
    mem_d = '0;
    mem_d.req = 1'h1;
    mem_d.size = eff_size(desc);
    mem_d.bit_pos = desc.bit_pos;
    mem_d.wdata = data_q;
    unique case (st_q)
      SCU_ST_PTR, SCU_ST_RPTR: begin
        mem_d.addr = desc.addr;
        mem_d.size = SCU_SZ_UNSIGNED_DOUBLE_WORD;
      end
      SCU_ST_SRC: mem_d.addr = ptr_q;
      SCU_ST_LWR: begin
        mem_d.we = 1'h1;
        mem_d.local_mem = 1'h1;
        mem_d.frame = depth_q[2:0];
        mem_d.addr = {9'h000, loc_byte};
        mem_d.bit_pos = loc_bit;
      end
      SCU_ST_RLRD: begin
        mem_d.local_mem = 1'h1;
        mem_d.frame = depth_q[2:0] - 3'h1;
        mem_d.addr = {9'h000, loc_byte};
        mem_d.bit_pos = loc_bit;
      end
      SCU_ST_RWR: begin
        mem_d.we = 1'h1;
        mem_d.addr = ptr_q;
      end
      default: mem_d.req = 1'h0;
    endcase
  end

  // One idle cycle between accesses keeps a stale ack from reissuing
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      mem_q <= '0;
    end else if (mem_ack) begin
      mem_q.req <= 1'h0;
    end else if (mem_st && !mem_q.req) begin
      mem_q <= mem_d;
    end
  end

  // ****************************************************************
  // Frames and nesting
  // ****************************************************************
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      depth_q <= 4'h0;
      isr_cnt_q <= 4'h0;
      for (int i = 0; i < 8; i++) begin
        frame_q[i] <= '0;
      end
    end else if (st_q == SCU_ST_ENTER) begin
      frame_q[depth_q[2:0]].ret_pc <= req_q.next_pc;
      frame_q[depth_q[2:0]].call_pc <= req_q.call_pc;
      frame_q[depth_q[2:0]].nparam <= req_q.nparam;
      frame_q[depth_q[2:0]].isr <= req_q.in_isr;
      frame_q[depth_q[2:0]].stack <= req_q.stack;
      depth_q <= depth_q + 4'h1;
      if (req_q.in_isr) begin
        isr_cnt_q <= isr_cnt_q + 4'h1;
      end
    end else if (st_q == SCU_ST_RESUME) begin
      depth_q <= depth_q - 4'h1;
      if (top.isr) begin
        isr_cnt_q <= isr_cnt_q - 4'h1;
      end
    end
  end

  // ****************************************************************
  // Answer to the sequencer
  // ****************************************************************
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      rsp_q <= '0;
    end else begin
      rsp_q <= '0;
      rsp_q.enable_out_flag <= 1'h1;
      unique case (st_q)
        SCU_ST_ENTER: begin
          rsp_q.valid <= 1'h1;
          rsp_q.act <= SCU_ACT_ENTER;
          rsp_q.subroutine_number <= req_q.subroutine_number;
          rsp_q.stack <= SCU_STACK_ENTRY;
        end
        SCU_ST_RESUME: begin
          rsp_q.valid <= 1'h1;
          rsp_q.act <= SCU_ACT_RESUME;
          rsp_q.pc <= top.ret_pc;
          rsp_q.stack <= top.stack;
        end
        SCU_ST_FAIL: begin
          rsp_q.valid <= 1'h1;
          rsp_q.act <= SCU_ACT_NEXT;
          rsp_q.pc <= req_q.next_pc;
          rsp_q.stack <= req_q.stack;
          rsp_q.enable_out_flag <= 1'h0;
          rsp_q.err <= err_q;
        end
        SCU_ST_NEXT: begin
          rsp_q.valid <= 1'h1;
          rsp_q.act <= SCU_ACT_NEXT;
          rsp_q.pc <= req_q.next_pc;
          rsp_q.stack <= req_q.stack;
        end
        default: rsp_q.valid <= 1'h0;
      endcase
    end
  end

  assign busy = busy_q;
  assign desc_pc = desc_pc_q;
  assign desc_idx = idx_q;
  assign mem = mem_q;
  assign rsp = rsp_q;
  assign depth = depth_q;

  // ****************************************************************
  // Checks
  // ****************************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  a_depth_limit: assert property (depth_q <= SCU_MAX_DEPTH)
    else $error("nesting depth above limit");
  a_enter_stack: assert property (rsp_q.valid && rsp_q.act == SCU_ACT_ENTER
    |-> rsp_q.stack == SCU_STACK_ENTRY && depth_q == $past(depth_q) + 4'h1)
    else $error("entry stack or depth wrong");
  a_fail_eno: assert property (st_q == SCU_ST_FAIL |=> !rsp_q.enable_out_flag
    && (rsp_q.err == SCU_ERR_NEST || rsp_q.err == SCU_ERR_INDIRECT))
    else $error("failed call kept enable out");
  a_fail_keep: assert property (st_q == SCU_ST_FAIL |=> $stable(depth_q))
    else $error("failed call moved depth");
  a_nest_err: assert property (st_q == SCU_ST_IDLE && req.op == SCU_OP_CALL
    && depth_q == SCU_MAX_DEPTH |=> ##1 rsp_q.err == SCU_ERR_NEST)
    else $error("nesting error code missing");
  a_conditional_return_false: assert property (st_q == SCU_ST_IDLE && req.op == SCU_OP_CONDITIONAL_RETURN
    && !req.stack[0] |=> st_q == SCU_ST_NEXT ##1 $stable(depth_q))
    else $error("conditional return taken on false");
  a_resume_pc: assert property (st_q == SCU_ST_RESUME |=> rsp_q.valid
    && rsp_q.pc == $past(top.ret_pc) && depth_q == $past(depth_q) - 4'h1)
    else $error("resume address or depth wrong");
  a_isr_nest: assert property (isr_cnt_q <= SCU_ISR_MAX_DEPTH)
    else $error("nested call below interrupt level");
  a_param_cnt: assert property (st_q != SCU_ST_IDLE |-> idx_q < SCU_MAX_PARAMS)
    else $error("parameter index beyond sixteen");
  a_no_local_fail: assert property (st_q == SCU_ST_CHECK && desc_bad(desc)
    |=> !(mem_q.req && mem_q.we) [*3])
    else $error("local write after failed check");

endmodule // scu_call_unit

// >>> verification/scu_mem_model.sv
/*
 * Sequencer and data memory model: descriptor table read by index,
 * byte memory for data and local frames, ack after 1 or 4 cycles.
 * Assumes the bench loads dtab and m by hierarchical access.
 */
`timescale 1ns/10ps
module scu_mem_model (
  input wire logic clk,
  input wire logic slow,
  input wire logic [4:0] desc_idx,
  input wire scu_pkg::scu_mem_s mem,
  output scu_pkg::scu_desc_s desc,
  output logic mem_ack,
  output logic [31:0] mem_rdata
);
  import scu_pkg::*;
  // ****************************************************************
  // Storage
  // ****************************************************************
  scu_desc_s dtab [0:15];
  logic [7:0] m [0:2047];
  logic [2:0] wait_q;
  logic [10:0] idx;
  logic [31:0] rd;
  int nb;
  // Bench loads in, in-out, out in order, with some illegal operands for the refusal cases
  assign desc = dtab[desc_idx[3:0]];
  assign idx = mem.local_mem ? {1'b1, mem.frame, mem.addr[6:0]} : {1'b0, mem.addr[9:0]};
  always_comb begin
    nb = (mem.size == SCU_SZ_UNSIGNED_DOUBLE_WORD) ? 4 : int'(mem.size);
    rd = 32'h0;
    for (int k = 0; k < 4; k++) begin
      if (k < nb) rd[8*k +: 8] = m[idx + 11'(k)];
    end
    if (mem.size == SCU_SZ_BIT) rd = {31'h0, m[idx][mem.bit_pos]};
  end
  initial begin
    mem_ack = 1'b0;
    mem_rdata = 32'h0;
    wait_q = 3'h0;
  end
  always @(posedge clk) begin
    if (mem.req && !mem_ack && !(slow && wait_q < 3'h3)) begin
      wait_q <= 3'h0;
      mem_ack <= 1'b1;
      mem_rdata <= rd;
      if (mem.we && mem.size == SCU_SZ_BIT) m[idx][mem.bit_pos] <= mem.wdata[0];
      for (int k = 0; k < 4; k++) begin
        if (mem.we && mem.size != SCU_SZ_BIT && k < nb) m[idx + 11'(k)] <= mem.wdata[8*k +: 8];
      end
    end else begin
      mem_ack <= 1'b0;
      // Idle data flips each cycle so a sample one cycle late sees the inverted value
      mem_rdata <= ~mem_rdata;
      if (mem.req && !mem_ack) wait_q <= wait_q + 3'h1;
    end
  end
endmodule // scu_mem_model

// >>> verification/scu_call_unit_test.sv
/*
 * Self-checking bench of the call unit: nesting, returns, interrupt
 * level, limits, parameter copy and refused operands.
 * Assumes the memory model answers descriptors and memory cycles.
 */
`timescale 1ns/10ps
module scu_call_unit_test;
  import scu_pkg::*;
  // ****************************************************************
  // Harness
  // ****************************************************************
  logic clk, sys_rst, slow, busy, mem_ack;
  scu_req_s req;
  scu_desc_s desc;
  scu_mem_s mem;
  scu_rsp_s rsp, got;
  logic [31:0] mem_rdata;
  logic [15:0] desc_pc;
  logic [4:0] desc_idx;
  logic [3:0] depth;
  int err_total, tests_run, cyc;
  scu_call_unit dut_u (.clk(clk), .sys_rst(sys_rst), .req(req), .desc(desc), .mem_ack(mem_ack),
    .mem_rdata(mem_rdata), .busy(busy), .desc_pc(desc_pc), .desc_idx(desc_idx), .mem(mem),
    .rsp(rsp), .depth(depth));
  scu_mem_model part_u (.clk(clk), .slow(slow), .desc_idx(desc_idx), .mem(mem), .desc(desc),
    .mem_ack(mem_ack), .mem_rdata(mem_rdata));
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  // Whole run needs a few hundred cycles
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      err_total++;
      close_out();
    end
  end
  task automatic close_out();
    if (err_total == 0 && tests_run > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      err_total++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // Return address encodes the depth so unwinding order shows in pc
  task automatic op(input scu_op_e o, input logic [6:0] n, input logic [4:0] np,
      input logic isr, input logic [31:0] stk);
    int k;
    k = 0;
    @(negedge clk);
    req = '{o, n, 16'h01FF + depth, 16'h0200 + depth, np, isr, stk};
    @(negedge clk);
    req.op = SCU_OP_NONE;
    while (rsp.valid !== 1'b1 && k < 300) begin
      @(negedge clk);
      k++;
    end
    got = rsp;
    chk({31'h0, rsp.valid}, 32'h1);
    while (busy !== 1'b0 && k < 300) begin
      @(negedge clk);
      k++;
    end
  endtask
  task automatic sd(input int i, input scu_dir_e d, input scu_size_e s, input scu_mode_e md,
      input logic [15:0] a, input logic [31:0] v, input logic [2:0] bp);
    part_u.dtab[i] = '{d, s, md, 1'b0, 1'b0, 2'h1, bp, a, v};
  endtask
  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic t_nest();
    for (int i = 0; i < 8; i++) begin
      op(SCU_OP_CALL, 7'h05, 5'h0, 1'b0, 32'hC0DE_0000 + i);
      chk({got.act, got.subroutine_number, depth}, {SCU_ACT_ENTER, 7'h05, 4'(i + 1)});
      chk(got.stack, SCU_STACK_ENTRY);
    end
    op(SCU_OP_CALL, 7'h05, 5'h0, 1'b0, 32'h0);
    chk({got.act, got.enable_out_flag, got.err, depth}, {SCU_ACT_NEXT, 1'b0, SCU_ERR_NEST, 4'h8});
    for (int i = 7; i >= 0; i--) begin
      op(SCU_OP_RET, 7'h0, 5'h0, 1'b0, 32'h0);
      chk({got.act, got.pc, depth}, {SCU_ACT_RESUME, 16'h0200 + 16'(i), 4'(i)});
      chk(got.stack, 32'hC0DE_0000 + i);
    end
  endtask
  task automatic t_conditional_return();
    op(SCU_OP_CALL, 7'h3F, 5'h0, 1'b0, 32'h5);
    op(SCU_OP_CONDITIONAL_RETURN, 7'h0, 5'h0, 1'b0, 32'h2);
    chk({got.act, depth}, {SCU_ACT_NEXT, 4'h1});
    op(SCU_OP_CONDITIONAL_RETURN, 7'h0, 5'h0, 1'b0, 32'h1);
    chk({got.act, got.stack, depth}, {SCU_ACT_RESUME, 32'h5, 4'h0});
  endtask
  task automatic t_isr();
    op(SCU_OP_CALL, 7'h01, 5'h0, 1'b1, 32'h0);
    chk({got.act, depth}, {SCU_ACT_ENTER, 4'h1});
    op(SCU_OP_CALL, 7'h01, 5'h0, 1'b1, 32'h0);
    chk({got.enable_out_flag, got.err, depth}, {1'b0, SCU_ERR_NEST, 4'h1});
    op(SCU_OP_RET, 7'h0, 5'h0, 1'b1, 32'h0);
  endtask
  task automatic t_limits();
    op(SCU_OP_CALL, 7'h7F, 5'h0, 1'b0, 32'h0);
    chk({got.act, got.subroutine_number}, {SCU_ACT_ENTER, 7'h7F});
    op(SCU_OP_RET, 7'h0, 5'h0, 1'b0, 32'h0);
    op(SCU_OP_CALL, 7'h02, 5'h11, 1'b0, 32'h0);
    chk({got.enable_out_flag, got.err, depth}, {1'b0, SCU_ERR_INDIRECT, 4'h0});
    op(SCU_OP_RET, 7'h0, 5'h0, 1'b0, 32'h0);
    chk({got.act, got.pc}, {SCU_ACT_NEXT, 16'h0200});
  endtask
  task automatic t_params();
    part_u.m[10] = 8'h08;
    part_u.m[20] = 8'h5A;
    sd(0, SCU_DIR_IN, SCU_SZ_BIT, SCU_MD_DIRECT, 16'hA, 32'h0, 3'h3);
    sd(1, SCU_DIR_IN, SCU_SZ_BIT, SCU_MD_CONST, 16'h0, 32'h1, 3'h0);
    sd(2, SCU_DIR_IN, SCU_SZ_WORD, SCU_MD_CONST, 16'h0, 32'h1234, 3'h0);
    sd(3, SCU_DIR_IN, SCU_SZ_BYTE, SCU_MD_ADDR, 16'h0, 32'h64, 3'h0);
    sd(4, SCU_DIR_INOUT, SCU_SZ_BYTE, SCU_MD_DIRECT, 16'h14, 32'h0, 3'h0);
    sd(5, SCU_DIR_OUT, SCU_SZ_WORD, SCU_MD_DIRECT, 16'h1E, 32'h0, 3'h0);
    slow = 1'b1;
    op(SCU_OP_CALL, 7'h02, 5'h6, 1'b0, 32'h0);
    chk({part_u.m[1024][1:0], part_u.m[1026], part_u.m[1025]}, {2'h3, 16'h1234});
    chk({part_u.m[1030], part_u.m[1029], part_u.m[1028], part_u.m[1027]}, 32'h64);
    chk(part_u.m[1031], 8'h5A);
    part_u.m[1031] = 8'hA5;
    part_u.m[1032] = 8'hEF;
    part_u.m[1033] = 8'hBE;
    op(SCU_OP_RET, 7'h0, 5'h0, 1'b0, 32'h0);
    chk({part_u.m[20], part_u.m[31], part_u.m[30]}, 24'hA5BEEF);
    chk(desc_pc, 16'h01FF);
    slow = 1'b0;
  endtask
  task automatic t_bad();
    part_u.m[1024] = 8'hEE;
    sd(0, SCU_DIR_IN, SCU_SZ_BYTE, SCU_MD_DIRECT, 16'h14, 32'h0, 3'h0);
    sd(1, SCU_DIR_INOUT, SCU_SZ_WORD, SCU_MD_CONST, 16'h0, 32'h1234, 3'h0);
    op(SCU_OP_CALL, 7'h02, 5'h2, 1'b0, 32'h0);
    chk({got.enable_out_flag, got.err, depth}, {1'b0, SCU_ERR_INDIRECT, 4'h0});
    sd(1, SCU_DIR_OUT, SCU_SZ_BYTE, SCU_MD_DIRECT, 16'h1D, 32'h0, 3'h0);
    part_u.dtab[1].special_memory = 1'b1;
    op(SCU_OP_CALL, 7'h02, 5'h2, 1'b0, 32'h0);
    chk({got.err, depth}, {SCU_ERR_INDIRECT, 4'h0});
    sd(1, SCU_DIR_IN, SCU_SZ_BYTE, SCU_MD_INDIRECT, 16'h0, 32'h10, 3'h0);
    part_u.dtab[1].acc_ind = 1'b1;
    part_u.dtab[1].acc_idx = 2'h0;
    op(SCU_OP_CALL, 7'h02, 5'h2, 1'b0, 32'h0);
    chk({got.enable_out_flag, got.err, depth}, {1'b0, SCU_ERR_INDIRECT, 4'h0});
    chk(part_u.m[1024], 8'hEE);
    part_u.dtab[1].acc_idx = 2'h1;
    sd(2, SCU_DIR_IN, SCU_SZ_BYTE, SCU_MD_INDIRECT, 16'h40, 32'h0, 3'h0);
    {part_u.m[16], part_u.m[17], part_u.m[64], part_u.m[65]} = 32'h3CC3_1100;
    op(SCU_OP_CALL, 7'h02, 5'h3, 1'b0, 32'h0);
    chk({part_u.m[1024], part_u.m[1025], part_u.m[1026]}, 24'hA53CC3);
    op(SCU_OP_RET, 7'h0, 5'h0, 1'b0, 32'h0);
  endtask
  initial begin
    sys_rst = 1'b1;
    slow = 1'b0;
    req = '0;
    err_total = 0;
    tests_run = 0;
    repeat (4) @(negedge clk);
    sys_rst = 1'b0;
    t_nest();
    t_conditional_return();
    t_isr();
    t_limits();
    t_params();
    t_bad();
    close_out();
  end
endmodule // scu_call_unit_test
